// ---- acs_seq_top.sv ----
// Converter input channel sequencer with APB control and status registers
//
// Overview of operation
// R1 - Config bits 1,0 (bit0 set) give two pseudo differential pairs.
// R2 - Both scan bits zero selects single-select mode, any channel any order.
// R3 - Single-select: host writes pick bits first; multiplexer takes that channel.
// R4 - Single-select: each write picks next channel only; no automatic advance.
// R5 - Scan bits both one: first conversion channel 0, then ascending channels.
// R6 - After last picked channel the scan wraps to channel 0 and repeats.
// R7 - Scan repeats until the host writes the control register again.
// R8 - Host leaves the control register alone during a scan.
// R9 - Reference select one: internal buffered reference drives the reference pin.
// R10 - Reference select zero: internal output off, external reference used.
// R11 - Both config bits zero: four independent single-ended channels.
// R12 - Config bit1 set, bit0 clear: two fully differential pairs.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module acs_seq_top (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // APB slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [acs_pkg::ACS_AW-1:0] paddr_i,
  input  wire logic [acs_pkg::ACS_DW-1:0] pwdata_i,
  output logic      [acs_pkg::ACS_DW-1:0] prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // Converter side
  input  wire logic                     conv_done_i,
  output logic      [1:0]               mux_chan_o,
  output logic                          single_ended_o,
  output logic                          pseudo_pair_o,
  output logic                          diff_pair_o,
  output logic                          ref_int_buf_en_o,
  output logic                          ref_ext_sel_o
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ACS_CTRL_W-1:0] ctrl;
    logic [ACS_DW-1:0]     rdata;
    logic                  err;
    logic                  single;
    logic                  pseudo;
    logic                  diff;
    logic                  ref_int;
  } acs_top_st_t;

  acs_top_st_t st_r;
  acs_top_st_t st_nxt;

  logic       wr_ctrl;
  logic       scan_wr;
  logic [1:0] seq_chan;
  logic       seq_scan;
  logic [1:0] cfg_wr;

  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  // ----------------------------------------------------------------
  function automatic acs_reg_t acs_decode(input logic [ACS_AW-1:0] a);
    acs_reg_t r;
    r = ACS_REG_NONE;
    if (a == ACS_OFS_CTRL) begin
      r = ACS_REG_CTRL;
    end else if (a == ACS_OFS_STAT) begin
      r = ACS_REG_STAT;
    end
    return r;
  endfunction

  // One setup cycle then one access cycle; no extra waits
  assign pready_o = 1'b1;
  assign wr_ctrl  = psel_i && penable_i && pwrite_i && (acs_decode(paddr_i) == ACS_REG_CTRL);
  assign scan_wr  = ({pwdata_i[ACS_B_SCAN1], pwdata_i[ACS_B_SCAN0]} == ACS_SCAN_ALL);
  assign cfg_wr   = {pwdata_i[ACS_B_CFG1], pwdata_i[ACS_B_CFG0]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Read data and error prepared in the setup cycle
    if (psel_i && !penable_i) begin
      st_nxt.rdata = '0;
      st_nxt.err   = 1'b0;
      case (acs_decode(paddr_i))
        ACS_REG_CTRL: begin
          st_nxt.rdata[ACS_CTRL_W-1:0] = st_r.ctrl;
        end
        ACS_REG_STAT: begin
          st_nxt.rdata[ACS_S_CHAN +: 2] = seq_chan;
          st_nxt.rdata[ACS_S_CFG +: 2]  = {st_r.ctrl[ACS_B_CFG1], st_r.ctrl[ACS_B_CFG0]};
          st_nxt.rdata[ACS_S_SCAN]      = seq_scan;
          st_nxt.rdata[ACS_S_VSRC]      = st_r.ref_int;
        end
        default: begin
          st_nxt.err = 1'b1;
        end
      endcase
    end
    if (wr_ctrl) begin
      st_nxt.ctrl    = pwdata_i[ACS_CTRL_W-1:0]; // R7
      st_nxt.single  = (cfg_wr == ACS_CFG_SINGLE); // R11
      st_nxt.pseudo  = (cfg_wr == ACS_CFG_PSEUDO); // R1
      st_nxt.diff    = (cfg_wr == ACS_CFG_DIFF); // R12
      st_nxt.ref_int = pwdata_i[ACS_B_VSRC]; // R9 R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r        <= '0;
      st_r.ctrl   <= ACS_CTRL_RST;
      st_r.single <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer; non-scan codes fall back to single-select
  // ----------------------------------------------------------------
  acs_chan_seq u_seq (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .load_i      (wr_ctrl),
    .scan_i      (scan_wr), // R2
    .pick_i      (pwdata_i[ACS_B_PICK1:ACS_B_PICK0]), // R3
    .conv_done_i (conv_done_i),
    .chan_o      (seq_chan),
    .scan_o      (seq_scan)
  );

  assign prdata_o         = st_r.rdata;
  assign pslverr_o        = st_r.err;
  assign mux_chan_o       = seq_chan;
  assign single_ended_o   = st_r.single;
  assign pseudo_pair_o    = st_r.pseudo;
  assign diff_pair_o      = st_r.diff;
  assign ref_int_buf_en_o = st_r.ref_int; // R9
  assign ref_ext_sel_o    = !st_r.ref_int; // R10

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_single;
    wr_ctrl && !scan_wr;
  endsequence

  sequence s_wr_scan;
    wr_ctrl && scan_wr;
  endsequence

  sequence s_scan_step;
    seq_scan && conv_done_i && !wr_ctrl;
  endsequence

  property p_pseudo;
    @(posedge clk_i) disable iff (reset_i)
      (wr_ctrl && cfg_wr == ACS_CFG_PSEUDO) |=> (pseudo_pair_o && !diff_pair_o && !single_ended_o);
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo pair not selected"); // R1

  property p_single_cfg;
    @(posedge clk_i) disable iff (reset_i)
      (wr_ctrl && cfg_wr == ACS_CFG_SINGLE) |=> (single_ended_o && !pseudo_pair_o && !diff_pair_o);
  endproperty
  a_single_cfg: assert property (p_single_cfg) else $error("single-ended not selected"); // R11

  property p_diff;
    @(posedge clk_i) disable iff (reset_i)
      (wr_ctrl && cfg_wr == ACS_CFG_DIFF) |=> (diff_pair_o && !pseudo_pair_o && !single_ended_o);
  endproperty
  a_diff: assert property (p_diff) else $error("differential pair not selected"); // R12

  property p_pick;
    logic [1:0] c;
    @(posedge clk_i) disable iff (reset_i)
      (s_wr_single, c = pwdata_i[1:0]) |=> (mux_chan_o == c && !seq_scan);
  endproperty
  a_pick: assert property (p_pick) else $error("picked channel not routed"); // R3

  property p_hold;
    @(posedge clk_i) disable iff (reset_i)
      (!seq_scan && !wr_ctrl) |=> $stable(mux_chan_o);
  endproperty
  a_hold: assert property (p_hold) else $error("channel moved in single-select"); // R4

  property p_scan_start;
    @(posedge clk_i) disable iff (reset_i)
      s_wr_scan |=> (mux_chan_o == ACS_CHAN0 && seq_scan);
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan did not start at 0"); // R5

  property p_scan_up;
    @(posedge clk_i) disable iff (reset_i)
      (s_scan_step and (mux_chan_o != st_r.ctrl[1:0]))
        |=> (mux_chan_o == 2'($past(mux_chan_o) + 2'h1));
  endproperty
  a_scan_up: assert property (p_scan_up) else $error("scan did not ascend"); // R5

  property p_wrap;
    @(posedge clk_i) disable iff (reset_i)
      (s_scan_step and (mux_chan_o == st_r.ctrl[1:0])) |=> (mux_chan_o == ACS_CHAN0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("scan did not wrap"); // R6

  property p_scan_keep;
    @(posedge clk_i) disable iff (reset_i)
      (seq_scan && !wr_ctrl) |=> seq_scan;
  endproperty
  a_scan_keep: assert property (p_scan_keep) else $error("scan ended without write"); // R7

  property p_ref;
    @(posedge clk_i) disable iff (reset_i)
      wr_ctrl |=> (ref_int_buf_en_o == $past(pwdata_i[ACS_B_VSRC]))
                  && (ref_ext_sel_o != ref_int_buf_en_o);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong"); // R9 R10

endmodule

// ---- acs_pkg.sv ----
// Package of constants and types for the converter input channel sequencer
package acs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ACS_AW         = 8;
  localparam int          ACS_DW         = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACS_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  ACS_OFS_STAT   = 8'h04;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          ACS_B_PICK0    = 0;
  localparam int          ACS_B_PICK1    = 1;
  localparam int          ACS_B_CFG0     = 2;
  localparam int          ACS_B_CFG1     = 3;
  localparam int          ACS_B_SCAN0    = 4;
  localparam int          ACS_B_SCAN1    = 5;
  localparam int          ACS_B_VSRC     = 6;
  localparam int          ACS_CTRL_W     = 7;
  localparam logic [6:0]  ACS_CTRL_RST   = 7'h00;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int          ACS_S_CHAN     = 0;
  localparam int          ACS_S_CFG      = 2;
  localparam int          ACS_S_SCAN     = 4;
  localparam int          ACS_S_VSRC     = 5;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  // Input arrangement, coded as {input_config_bit1, input_config_bit0}
  typedef enum logic [1:0] {
    ACS_CFG_SINGLE = 2'b00,
    ACS_CFG_PSEUDO = 2'b01,
    ACS_CFG_DIFF   = 2'b10,
    ACS_CFG_RSVD   = 2'b11
  } acs_cfg_t;

  // Selection scheme, coded as {scan_ctrl_bit1, scan_ctrl_bit0}
  localparam logic [1:0]  ACS_SCAN_ALL   = 2'b11;

  // Register decode result
  typedef enum logic [1:0] {
    ACS_REG_CTRL = 2'b00,
    ACS_REG_STAT = 2'b01,
    ACS_REG_NONE = 2'b10
  } acs_reg_t;

  localparam logic [1:0]  ACS_CHAN0      = 2'h0;

endpackage

// ---- acs_chan_seq.sv ----
// Channel sequencer: single-select hold or ascending scan with wrap
`timescale 1ns/1ps
module acs_chan_seq (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control register load
  input  wire logic       load_i,
  input  wire logic       scan_i,
  input  wire logic [1:0] pick_i,
  // Converter side
  input  wire logic       conv_done_i,
  output logic      [1:0] chan_o,
  output logic            scan_o
);
  import acs_pkg::*;

  typedef struct packed {
    logic       scan;
    logic [1:0] last;
    logic [1:0] chan;
  } acs_seq_st_t;

  acs_seq_st_t st_r;
  acs_seq_st_t st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Write wins over a conversion in the same cycle
    if (load_i) begin
      st_nxt.scan = scan_i;
      st_nxt.last = pick_i;
      st_nxt.chan = scan_i ? ACS_CHAN0 : pick_i; // R3 R5
    end else if (conv_done_i && st_r.scan) begin
      if (st_r.chan == st_r.last) begin
        st_nxt.chan = ACS_CHAN0; // R6
      end else begin
        st_nxt.chan = 2'(st_r.chan + 2'h1); // R5 R7
      end
    end
    // Single-select holds its channel between conversions: R4
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chan_o = st_r.chan;
  assign scan_o = st_r.scan;

endmodule

// ---- acs_conv_model.sv ----
// Behavioural converter model that answers conversion requests after a delay
`timescale 1ns/1ps
module acs_conv_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Request from the bench
  input  wire logic       start_i,
  input  wire logic [3:0] delay_i,
  // Sequencer side
  input  wire logic [1:0] chan_i,
  output logic            conv_done_o,
  output logic      [1:0] chan_taken_o
);
  // ----------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------
  logic       busy_r;
  logic [3:0] cnt_r;

  // Channel latched at the edge that raises done, one edge before the sequencer sees done
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_r       <= 1'b0;
      cnt_r        <= 4'h0;
      conv_done_o  <= 1'b0;
      chan_taken_o <= 2'h0;
    end else begin
      conv_done_o <= 1'b0;
      if (start_i && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r  <= delay_i;
      end else if (busy_r) begin
        if (cnt_r == 4'h0) begin
          busy_r       <= 1'b0;
          conv_done_o  <= 1'b1;
          chan_taken_o <= chan_i;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule

// ---- acs_seq_top_tb.sv ----
// Self-checking testbench for the converter input channel sequencer
`timescale 1ns/1ps
module acs_seq_top_tb;
  import acs_pkg::*;
  logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        conv_done, start, se, ps, df, ri, re, e;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, q, d;
  logic [1:0]  mux, ch, taken;
  logic [3:0]  dly;
  int          num_errors, n_checks, k, n;
  logic [1:0]  picks [4] = '{2'h3, 2'h1, 2'h0, 2'h2};

  acs_seq_top i_acs_seq_top (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .conv_done_i(conv_done), .mux_chan_o(mux), .single_ended_o(se), .pseudo_pair_o(ps),
    .diff_pair_o(df), .ref_int_buf_en_o(ri), .ref_ext_sel_o(re));
  acs_conv_model i_acs_conv_model (.clk_i(clk_i), .reset_i(reset_i), .start_i(start),
    .delay_i(dly), .chan_i(mux), .conv_done_o(conv_done), .chan_taken_o(taken));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) begin
        q = prdata_o;
        e = pslverr_o;
        break;
      end
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (i == 50) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // Outputs are registered off the control register, so allow two edges
  task automatic outs(input logic [1:0] c, input logic [1:0] m, input logic v);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({25'h0, mux, se, ps, df, ri, re},
          {25'h0, c, m == 2'd0, m == 2'd1, m == 2'd2, v, !v});
  endtask

  task automatic convert(input logic [3:0] dl);
    int i;
    @(posedge clk_i);
    start <= 1'b1;
    dly   <= dl;
    @(posedge clk_i);
    start <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_i);
      if (conv_done === 1'b1) break;
    end
    ch = taken;
    if (i == 50) begin
      num_errors++;
      test_done();
    end
  endtask

  // ----------------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    num_errors = 0;
    n_checks   = 0;
    reset_i    = 1'b1;
    psel_i     = 1'b0;
    penable_i  = 1'b0;
    pwrite_i   = 1'b0;
    paddr_i    = 8'h00;
    pwdata_i   = 32'h0;
    start      = 1'b0;
    dly        = 4'h0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    outs(2'h0, 2'h0, 1'b0);
    rd(ACS_OFS_CTRL, 32'h0);
    // Every input arrangement with both reference sources
    for (k = 0; k < 8; k++) begin
      d = {25'h0, k[2], 2'b00, k[1:0], 2'b01};
      apb(1'b1, ACS_OFS_CTRL, d);
      outs(2'h1, k[1:0], k[2]);
      rd(ACS_OFS_CTRL, d);
      rd(ACS_OFS_STAT, {26'h0, k[2], 1'b0, k[1:0], 2'b01});
    end
    // Single-select in arbitrary order, no advance after a conversion
    for (k = 0; k < 4; k++) begin
      apb(1'b1, ACS_OFS_CTRL, {30'h0, picks[k]});
      outs(picks[k], 2'h0, 1'b0);
      convert(k[3:0]);
      check({30'h0, ch}, {30'h0, picks[k]});
      outs(picks[k], 2'h0, 1'b0);
    end
    // Scan codes 01 and 10 fall back to single-select with no advance
    apb(1'b1, ACS_OFS_CTRL, 32'h13);
    outs(2'h3, 2'h0, 1'b0);
    convert(4'h1);
    check({30'h0, ch}, 32'h3);
    outs(2'h3, 2'h0, 1'b0);
    apb(1'b1, ACS_OFS_CTRL, 32'h22);
    outs(2'h2, 2'h0, 1'b0);
    convert(4'h2);
    check({30'h0, ch}, 32'h2);
    outs(2'h2, 2'h0, 1'b0);
    // Scan to channel 2; host keeps off the register meanwhile
    apb(1'b1, ACS_OFS_CTRL, 32'h32);
    outs(2'h0, 2'h0, 1'b0);
    for (n = 0; n < 7; n++) begin
      convert(n[3:0] & 4'h3);
      check({30'h0, ch}, n % 3);
    end
    // New write mid-scan restarts at channel 0 with the new last channel
    apb(1'b1, ACS_OFS_CTRL, 32'h31);
    outs(2'h0, 2'h0, 1'b0);
    rd(ACS_OFS_STAT, 32'h10);
    for (n = 0; n < 3; n++) begin
      convert(4'h0);
      check({30'h0, ch}, n % 2);
    end
    // Unmapped place and read-only status leave the control register alone
    apb(1'b1, 8'h08, 32'h7f);
    check({31'h0, e}, 32'h1);
    rd(8'h08, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, ACS_OFS_STAT, 32'h7f);
    check({31'h0, e}, 32'h0);
    rd(ACS_OFS_CTRL, 32'h31);
    test_done();
  end
endmodule
